// file: logic/mil_pkg.sv
/*
  metering interrupt logic: register offsets, flag positions, reset values.
  assumes byte-wide register addresses as seen by the device's serial port.
*/
package mil_pkg;
  localparam int FLAG_W = 20;
  localparam int ADDR_W = 8;
  localparam int MODE_W = 8;
  localparam int ACC_W = 16;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE_BITS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h19;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS_CLEAR_ON_READ = 8'h1A;
  // reset values
  localparam logic [FLAG_W-1:0] IRQ_ENABLE_RST = 20'h00000;
  localparam logic [FLAG_W-1:0] EVENT_FLAGS_RST = 20'h00000;
  // bit 13 of the enable register is reserved and not writable
  localparam logic [FLAG_W-1:0] IRQ_ENABLE_WRITABLE = 20'hFDFFF;
  // flag positions
  localparam int BIT_ACTIVE_ENERGY_HALF_FULL = 0;
  localparam int BIT_REACTIVE_ENERGY_HALF_FULL = 1;
  localparam int BIT_APPARENT_ENERGY_HALF_FULL = 2;
  localparam int BIT_SAG_PHASE_A = 3;
  localparam int BIT_CROSSING_TIMEOUT_A = 6;
  localparam int BIT_VOLTAGE_CROSSING_A = 9;
  localparam int BIT_LINE_ACCUM_DONE = 12;
  localparam int BIT_SUPPLY_RESET = 13;
  localparam int BIT_VOLTAGE_PEAK_EXCEEDED = 14;
  localparam int BIT_CURRENT_PEAK_EXCEEDED = 15;
  localparam int BIT_WAVEFORM_SAMPLE_READY = 16;
  localparam int BIT_ACTIVE_POWER_SIGN_FLIP = 17;
  localparam int BIT_REACTIVE_POWER_SIGN_FLIP = 18;
  localparam int BIT_PHASE_ORDER_ERROR = 19;
  // accumulator bits watched for half full
  localparam int ACC_HALF_BIT = 14;
  localparam int ACC_MSB_BIT = 15;
  // phase include select field of the computation mode register
  localparam int PHASE_INCLUDE_SELECT_LSB = 2;
  // phase order tracker states, one-hot
  typedef enum logic [1:0] {
    MIL_SEQ_IDLE = 2'h1,
    MIL_SEQ_AFTER_A = 2'h2
  } mil_seq_e;
endpackage

// file: logic/mil_metering_interrupt_logic.sv
/*
  metering interrupt logic: nineteen sticky event flags plus a one-cycle bit 13, enable register,
  clear-on-read status copy and an open-drain active-low request pin.
  assumes event inputs are synchronous one-cycle pulses or levels from the
  detectors, and a register port decoded from the serial interface.
*/
`timescale 1ns/1ps
module mil_metering_interrupt_logic (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [mil_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mil_pkg::FLAG_W-1:0] reg_wdata,
  output logic [mil_pkg::FLAG_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // accumulators, one word per phase
  input wire logic [2:0][mil_pkg::ACC_W-1:0] active_energy_accum,
  input wire logic [2:0][mil_pkg::ACC_W-1:0] reactive_energy_accum,
  input wire logic [2:0][mil_pkg::ACC_W-1:0] apparent_energy_accum,
  // detector pulses, bit 0 is phase A
  input wire logic [2:0] sag_phase,
  input wire logic [2:0] crossing_timeout,
  input wire logic [2:0] voltage_crossing,
  input wire logic line_accum_done,
  input wire logic voltage_peak_exceeded,
  input wire logic current_peak_exceeded,
  input wire logic waveform_sample_ready,
  input wire logic supply_low,
  // power signs per phase, levels, and the computation mode register
  input wire logic [2:0] active_power_sign,
  input wire logic [2:0] reactive_power_sign,
  input wire logic [mil_pkg::MODE_W-1:0] computation_mode_reg,
  // open-drain request pin
  output logic irq_n_o,
  output logic irq_n_oe
);

  logic [mil_pkg::FLAG_W-1:0] ev;
  logic [mil_pkg::FLAG_W-1:0] flags_q, flags_d;
  logic [mil_pkg::FLAG_W-1:0] enable_q, enable_d;
  logic [mil_pkg::FLAG_W-1:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic irq_q, irq_d;
  logic irq_n_q, irq_n_d;
  logic rst_pulse_q, rst_pulse_d;
  logic primed_q, primed_d;
  logic [2:0] act_half_q, act_half_d;
  logic [2:0] react_half_q, react_half_d;
  logic [2:0] app_msb_q, app_msb_d;
  logic [2:0] act_sign_q, act_sign_d;
  logic [2:0] react_sign_q, react_sign_d;
  mil_pkg::mil_seq_e seq_q, seq_d;
  logic seq_err;
  logic [2:0] incl;
  logic clr_rd;
  logic stat_rd;

  assign clr_rd = reg_rd &&
    (reg_addr == mil_pkg::OFS_EVENT_FLAGS_CLEAR_ON_READ);
  assign stat_rd = reg_rd && (reg_addr == mil_pkg::OFS_EVENT_FLAGS);
  assign incl = computation_mode_reg[
    mil_pkg::PHASE_INCLUDE_SELECT_LSB +: 3];

  // history of watched bits; primed blocks a false edge after reset
  always_comb begin
    primed_d = 1'b1;
    for (int p = 0; p < 3; p++) begin
      act_half_d[p] = active_energy_accum[p][mil_pkg::ACC_HALF_BIT];
      react_half_d[p] = reactive_energy_accum[p][mil_pkg::ACC_HALF_BIT];
      app_msb_d[p] = apparent_energy_accum[p][mil_pkg::ACC_MSB_BIT];
    end
    act_sign_d = active_power_sign;
    react_sign_d = reactive_power_sign;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      primed_q <= 1'b0;
      act_half_q <= 3'h0;
      react_half_q <= 3'h0;
      app_msb_q <= 3'h0;
      act_sign_q <= 3'h0;
      react_sign_q <= 3'h0;
    end else begin
      primed_q <= primed_d;
      act_half_q <= act_half_d;
      react_half_q <= react_half_d;
      app_msb_q <= app_msb_d;
      act_sign_q <= act_sign_d;
      react_sign_q <= react_sign_d;
    end
  end

  // phase order tracker: after an A crossing the next must be C, not B
  always_comb begin
    seq_d = seq_q;
    seq_err = 1'b0;
    case (seq_q)
      mil_pkg::MIL_SEQ_IDLE: begin
        if (voltage_crossing[0]) begin
          seq_d = mil_pkg::MIL_SEQ_AFTER_A;
        end
      end
      mil_pkg::MIL_SEQ_AFTER_A: begin
        if (voltage_crossing[1]) begin
          seq_err = 1'b1;
          seq_d = mil_pkg::MIL_SEQ_IDLE;
        end else if (voltage_crossing[2]) begin
          seq_d = mil_pkg::MIL_SEQ_IDLE;
        end
      end
      default: begin
        seq_d = mil_pkg::MIL_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seq_q <= mil_pkg::MIL_SEQ_IDLE;
    end else begin
      seq_q <= seq_d;
    end
  end

  // event vector, one bit per flag
  always_comb begin
    ev = '0;
    ev[mil_pkg::BIT_ACTIVE_ENERGY_HALF_FULL] = primed_q &&
      |(act_half_d ^ act_half_q);
    ev[mil_pkg::BIT_REACTIVE_ENERGY_HALF_FULL] = primed_q &&
      |(react_half_d ^ react_half_q);
    ev[mil_pkg::BIT_APPARENT_ENERGY_HALF_FULL] = primed_q &&
      |(app_msb_d & ~app_msb_q);
    ev[mil_pkg::BIT_SAG_PHASE_A +: 3] = sag_phase;
    ev[mil_pkg::BIT_CROSSING_TIMEOUT_A +: 3] = crossing_timeout;
    ev[mil_pkg::BIT_VOLTAGE_CROSSING_A +: 3] = voltage_crossing;
    ev[mil_pkg::BIT_LINE_ACCUM_DONE] = line_accum_done;
    ev[mil_pkg::BIT_VOLTAGE_PEAK_EXCEEDED] =
      voltage_peak_exceeded;
    ev[mil_pkg::BIT_CURRENT_PEAK_EXCEEDED] =
      current_peak_exceeded;
    ev[mil_pkg::BIT_WAVEFORM_SAMPLE_READY] =
      waveform_sample_ready;
    ev[mil_pkg::BIT_ACTIVE_POWER_SIGN_FLIP] = primed_q &&
      |((act_sign_d ^ act_sign_q) & incl);
    ev[mil_pkg::BIT_REACTIVE_POWER_SIGN_FLIP] = primed_q &&
      |((react_sign_d ^ react_sign_q) & incl);
    ev[mil_pkg::BIT_PHASE_ORDER_ERROR] = seq_err;
  end

  // sticky flags; an event in the clearing cycle survives the clear
  for (genvar i = 0; i < mil_pkg::FLAG_W; i++) begin : g_flag
    if (i == mil_pkg::BIT_SUPPLY_RESET) begin : g_pulse
      assign flags_d[i] = 1'b0;
    end else begin : g_sticky
      always_comb begin
        flags_d[i] = ev[i] || (flags_q[i] && !clr_rd);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flags_q <= mil_pkg::EVENT_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // bit 13 is a one-cycle pulse, not sticky
  always_comb begin
    rst_pulse_d = supply_low;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rst_pulse_q <= 1'b1;
    end else begin
      rst_pulse_q <= rst_pulse_d;
    end
  end

  // register port and request latch
  always_comb begin
    enable_d = enable_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (reg_wr && reg_addr == mil_pkg::OFS_IRQ_ENABLE_BITS) begin
      enable_d = reg_wdata & mil_pkg::IRQ_ENABLE_WRITABLE;
    end
    if (reg_rd) begin
      rvalid_d = 1'b1;
      rdata_d = '0;
      if (reg_addr == mil_pkg::OFS_IRQ_ENABLE_BITS) begin
        rdata_d = enable_q;
      end else if (stat_rd || clr_rd) begin
        rdata_d = flags_q;
        rdata_d[mil_pkg::BIT_SUPPLY_RESET] = rst_pulse_q;
      end
    end
    // new enabled event wins over the release
    irq_d = |(ev & enable_q) || (irq_q && !clr_rd);
    irq_n_d = !irq_d;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      enable_q <= mil_pkg::IRQ_ENABLE_RST;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
      irq_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      enable_q <= enable_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      irq_q <= irq_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign irq_n_o = irq_n_q;
  assign irq_n_oe = irq_q;

  a_irq_assert: assert property (
    @(posedge mclk) disable iff (!rstn)
    |(ev & enable_q) |=> irq_n_oe && !irq_n_o)
    else $error("enabled event did not pull request low");
  a_irq_release: assert property (
    @(posedge mclk) disable iff (!rstn)
    clr_rd && !(|(ev & enable_q)) |=> !irq_n_oe)
    else $error("clear-on-read did not release request");
  a_flag_set: assert property (
    @(posedge mclk) disable iff (!rstn)
    (ev & ~enable_q) != '0 |=> (flags_q & $past(ev) & ~$past(enable_q))
      == ($past(ev) & ~$past(enable_q)))
    else $error("disabled event did not set its flag");
  a_flag_sticky: assert property (
    @(posedge mclk) disable iff (!rstn)
    !reg_rd ##1 !reg_rd |-> (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped without a clear read");
  a_clear_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    clr_rd && ev == '0 |=> flags_q == '0 && reg_rvalid &&
      (reg_rdata | 20'h02000) == ($past(flags_q) | 20'h02000))
    else $error("clear-on-read returned or cleared wrong");
  a_stat_read: assert property (
    @(posedge mclk) disable iff (!rstn)
    stat_rd |=> (flags_q & $past(flags_q)) == $past(flags_q) &&
      (!$past(irq_q) || irq_n_oe))
    else $error("plain status read modified state");
  a_seq_err: assert property (
    @(posedge mclk) disable iff (!rstn)
    voltage_crossing == 3'h1 ##1 voltage_crossing == 3'h0 [*2]
      ##1 voltage_crossing == 3'h2
      |=> flags_q[mil_pkg::BIT_PHASE_ORDER_ERROR])
    else $error("phase order error not flagged");
  a_sign_gate: assert property (
    @(posedge mclk) disable iff (!rstn)
    primed_q && |((active_power_sign ^ act_sign_q) & incl)
      |=> flags_q[mil_pkg::BIT_ACTIVE_POWER_SIGN_FLIP])
    else $error("included sign change not flagged");
  a_rst_bit13: assert property (
    @(posedge mclk) disable iff (!rstn)
    stat_rd && !$past(supply_low) && $past(rstn)
      |=> !reg_rdata[mil_pkg::BIT_SUPPLY_RESET])
    else $error("bit 13 held longer than one cycle");
  a_half_full: assert property (
    @(posedge mclk) disable iff (!rstn)
    primed_q && $rose(apparent_energy_accum[0][mil_pkg::ACC_MSB_BIT])
      |=> flags_q[mil_pkg::BIT_APPARENT_ENERGY_HALF_FULL])
    else $error("apparent half full not flagged");
  a_active_half: assert property (
    @(posedge mclk) disable iff (!rstn)
    primed_q && $changed(active_energy_accum[1][mil_pkg::ACC_HALF_BIT])
      |=> flags_q[mil_pkg::BIT_ACTIVE_ENERGY_HALF_FULL])
    else $error("active half full not flagged");
  a_react_sign: assert property (
    @(posedge mclk) disable iff (!rstn)
    primed_q && incl[2] && $changed(reactive_power_sign[2])
      |=> flags_q[mil_pkg::BIT_REACTIVE_POWER_SIGN_FLIP])
    else $error("included reactive sign change not flagged");
  a_sag_flag: assert property (
    @(posedge mclk) disable iff (!rstn)
    sag_phase[1] |=> flags_q[mil_pkg::BIT_SAG_PHASE_A + 1])
    else $error("phase b sag not flagged");
  a_supply_pulse: assert property (
    @(posedge mclk) disable iff (!rstn)
    stat_rd && $past(supply_low) |=> reg_rdata[mil_pkg::BIT_SUPPLY_RESET])
    else $error("supply low pulse not reported on bit 13");

endmodule

// file: verif/mil_host_model.sv
/*
  host model: register reads, writes and the interrupt service sequence.
  assumes every task is entered at a rising mclk edge.
*/
`timescale 1ns/1ps
module mil_host_model (
  // clock
  input wire logic mclk,
  // register port
  output logic reg_rd,
  output logic reg_wr,
  output logic [mil_pkg::ADDR_W-1:0] reg_addr,
  output logic [mil_pkg::FLAG_W-1:0] reg_wdata,
  input wire logic [mil_pkg::FLAG_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 20'h00000;
  end

  // idle address and data are inverted so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge mclk);
  endtask

  // a missing answer leaves d unknown, so the caller's compare fails
  task automatic rd(input logic [7:0] a, output logic [19:0] d);
    d = 'x;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
    end
  endtask

  task automatic service(output logic [19:0] st, output logic [19:0] cl);
    rd(mil_pkg::OFS_EVENT_FLAGS, st);
    rd(mil_pkg::OFS_EVENT_FLAGS_CLEAR_ON_READ, cl);
  endtask
endmodule

// file: verif/testbench.sv
/*
  testbench: reset checks, event table loop, then phase order, exclusion, supply low and collision cases.
  assumes the host model owns the register port; events driven here.
*/
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  error_cnt++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic mclk, rstn, rd, wr, rvalid, irq_o, irq_oe, sl;
  logic [7:0] addr, cm;
  logic [19:0] wdata, rdata, d, st, cl, m;
  logic [12:0] ev;
  logic [2:0][15:0] aea, rea, apa;
  logic [2:0] aps, rps;
  int error_cnt, samples_checked;
  // event kind beside the flag bit it must raise
  int rows [18][2] = '{'{0, 3}, '{1, 4}, '{2, 5},
    '{3, 6}, '{4, 7}, '{5, 8},
    '{7, 10}, '{6, 9}, '{8, 11}, '{9, 12},
    '{10, 14}, '{11, 15}, '{12, 16},
    '{13, 0}, '{14, 1}, '{15, 2},
    '{16, 17}, '{17, 18}};

  mil_host_model host (.mclk(mclk), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid));
  mil_metering_interrupt_logic dut (.mclk(mclk), .rstn(rstn), .reg_rd(rd),
    .reg_wr(wr), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .active_energy_accum(aea),
    .reactive_energy_accum(rea), .apparent_energy_accum(apa),
    .sag_phase(ev[2:0]), .crossing_timeout(ev[5:3]),
    .voltage_crossing(ev[8:6]), .line_accum_done(ev[9]),
    .voltage_peak_exceeded(ev[10]), .current_peak_exceeded(ev[11]),
    .waveform_sample_ready(ev[12]), .supply_low(sl),
    .active_power_sign(aps), .reactive_power_sign(rps),
    .computation_mode_reg(cm), .irq_n_o(irq_o), .irq_n_oe(irq_oe));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // pulses are one cycle; accumulators and signs stay where they are left
  task automatic fire(input int k);
    case (k)
      13: aea[1][14] <= ~aea[1][14];
      14: rea[2][14] <= ~rea[2][14];
      15: apa[0][15] <= 1'b1;
      16: aps[0] <= ~aps[0];
      17: rps[2] <= ~rps[2];
      default: ev <= 13'h0001 << k;
    endcase
    @(posedge mclk);
    ev <= 13'h0000;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test;
  end

  initial begin
    rstn = 1'b0;
    ev = 13'h0000;
    aea = '0;
    rea = '0;
    apa = '0;
    aps = 3'h0;
    rps = 3'h0;
    sl = 1'b0;
    cm = 8'h1C;
    repeat (5) @(posedge mclk);
    `CHK("irq_oe_reset", 1'b0, irq_oe)
    `CHK("irq_o_reset", 1'b1, irq_o)
    rstn <= 1'b1;
    host.rd(mil_pkg::OFS_EVENT_FLAGS, d);
    `CHK("flags_first", 20'h02000, d)
    host.rd(mil_pkg::OFS_EVENT_FLAGS, d);
    `CHK("flags_second", 20'h00000, d)
    host.rd(mil_pkg::OFS_IRQ_ENABLE_BITS, d);
    `CHK("enable_reset", mil_pkg::IRQ_ENABLE_RST, d)
    host.wr(mil_pkg::OFS_IRQ_ENABLE_BITS, 20'hFFFFF);
    host.rd(mil_pkg::OFS_IRQ_ENABLE_BITS, d);
    `CHK("enable_rw", mil_pkg::IRQ_ENABLE_WRITABLE, d)
    host.rd(8'h20, d);
    `CHK("unmapped", 20'h00000, d)
    $display("test reset done");
    // odd rows enable every source except their own
    for (int i = 0; i < 18; i++) begin
      m = 20'h00001 << rows[i][1];
      host.wr(mil_pkg::OFS_IRQ_ENABLE_BITS, i % 2 == 0 ? m : 20'hFFFFF ^ m);
      fire(rows[i][0]);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK("irq_oe", i % 2 == 0, irq_oe)
      `CHK("irq_o", i % 2 != 0, irq_o | ~irq_oe)
      @(posedge mclk);
      host.service(st, cl);
      `CHK("flags", m, st)
      `CHK("flags_clear", m, cl)
      @(negedge mclk);
      `CHK("irq_released", 1'b0, irq_oe)
      @(posedge mclk);
      host.rd(mil_pkg::OFS_EVENT_FLAGS, d);
      `CHK("flags_after", 20'h00000, d)
      $display("test row %0d done", i);
    end
    // two quiet cycles between the crossings: the tracker must stay armed
    ev <= 13'h0040;
    @(posedge mclk);
    ev <= 13'h0000;
    repeat (2) @(posedge mclk);
    ev <= 13'h0080;
    @(posedge mclk);
    ev <= 13'h0000;
    repeat (3) @(posedge mclk);
    host.service(st, cl);
    `CHK("order_status", 20'h80600, st)
    `CHK("order_error", 20'h80600, cl)
    $display("test phase order done");
    cm <= 8'h04;
    aps[1] <= ~aps[1];
    rps[2] <= ~rps[2];
    apa[0][15] <= 1'b0;
    repeat (3) @(posedge mclk);
    host.rd(mil_pkg::OFS_EVENT_FLAGS, d);
    `CHK("excluded", 20'h00000, d)
    $display("test exclusion done");
    sl <= 1'b1;
    @(posedge mclk);
    sl <= 1'b0;
    host.rd(mil_pkg::OFS_EVENT_FLAGS, d);
    `CHK("supply_pulse", 20'h02000, d)
    host.rd(mil_pkg::OFS_EVENT_FLAGS, d);
    `CHK("supply_gone", 20'h00000, d)
    `CHK("supply_no_irq", 1'b0, irq_oe)
    $display("test supply low done");
    // sag on phase a lands on the very edge that takes the clearing read
    ev <= 13'h0001;
    fork
      host.rd(mil_pkg::OFS_EVENT_FLAGS_CLEAR_ON_READ, cl);
      begin
        @(posedge mclk);
        ev <= 13'h0000;
      end
    join
    `CHK("collide_read", 20'h00000, cl)
    `CHK("collide_irq", 1'b1, irq_oe)
    host.service(st, cl);
    `CHK("collide_flag", 20'h00008, st)
    `CHK("collide_clear", 20'h00008, cl)
    $display("test set beats clear done");
    stop_test;
  end
endmodule
